// ==== design/adc_link_ctrl_pkg.sv ====
// Constants for the converter output and serial link control registers
// What this block does
// RQ1: Sticky overrange status, one bit per converter
// RQ2: Writing 1 to clear bit clears matching status
// RQ3: Swap bit exchanges the two converter channels
// RQ4: Lane rate field bits 7:4, reset 3
// RQ5: PLL loss of lock sets sticky bit 3
// RQ6: Loss of lock cleared only by control bit 0
// RQ7: Value fe enables fixed quad rate preset
// RQ8: Value ff uses separate lane, converter, octet settings
// RQ9: Standby with select 0 sends zero samples
// RQ10: Standby with select 1 forces code group sync
// RQ11: Overrange clear register is eight bit read/write
// RQ12: Control bit 0 powers down transmit link
// RQ13: Event in clear cycle keeps sticky bit set
package adc_link_ctrl_pkg;

   localparam int unsigned ADDR_W = 12;
   localparam int unsigned SAMPLE_W = 16;
   localparam int unsigned NUM_CONV = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [11:0] OFS_OVR_CLEAR    = 12'h562;
   localparam logic [11:0] OFS_OVR_STATUS   = 12'h563;
   localparam logic [11:0] OFS_CHANNEL_SEL  = 12'h564;
   localparam logic [11:0] OFS_PLL_CONTROL  = 12'h56e;
   localparam logic [11:0] OFS_PLL_STATUS   = 12'h56f;
   localparam logic [11:0] OFS_QUAD_RATE    = 12'h570;
   localparam logic [11:0] OFS_LINK_CTRL1   = 12'h571;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int unsigned SWAP_BIT       = 0;
   localparam int unsigned LANE_RATE_LSB  = 4;
   localparam int unsigned LOCK_BIT       = 7;
   localparam int unsigned LOSS_BIT       = 3;
   localparam int unsigned STANDBY_BIT    = 7;
   localparam int unsigned POWERDOWN_BIT  = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_OVR_CLEAR   = 8'h00;
   localparam logic       RST_SWAP        = 1'h0;
   localparam logic [3:0] RST_LANE_RATE   = 4'h3;
   localparam logic [7:0] RST_QUAD_RATE   = 8'hff;
   localparam logic [7:0] RST_LINK_CTRL1  = 8'h14;

   ////////////////////////////////////////////////////////////////////////////
   // Lane rate codes
   localparam logic [3:0] RATE_6G75_13G5  = 4'h0;
   localparam logic [3:0] RATE_3G375_6G75 = 4'h1;
   localparam logic [3:0] RATE_13G5_16G   = 4'h3;
   localparam logic [3:0] RATE_1G69_3G375 = 4'h5;

   ////////////////////////////////////////////////////////////////////////////
   // Quad rate preset
   localparam logic [7:0] QUAD_RATE_ON    = 8'hfe;
   localparam logic [7:0] QUAD_RATE_OFF   = 8'hff;
   localparam logic [4:0] PRESET_LANES    = 5'h08;
   localparam logic [7:0] PRESET_CONV     = 8'h02;
   localparam logic [7:0] PRESET_OCTETS   = 8'h02;
   localparam logic [7:0] PRESET_SAMPLES  = 8'h04;
   localparam logic [7:0] PRESET_RES      = 8'h10;
   localparam logic [7:0] PRESET_WIDTH    = 8'h10;
   localparam logic [1:0] PRESET_CTRL_BITS = 2'h0;
   localparam logic [1:0] PRESET_CTRL_WORDS = 2'h0;
   localparam logic       PRESET_HD       = 1'h0;

endpackage

// ==== design/sticky_if.sv ====
// Carrier between the register bank and its sticky flag banks
interface sticky_if #(parameter int unsigned W = 8);
   logic [W-1:0] event_set;
   logic [W-1:0] clear;
   logic [W-1:0] flags;

   modport bank
   (
      input  event_set,
      input  clear,
      output flags
   );

   modport owner
   (
      output event_set,
      output clear,
      input  flags
   );
endinterface

// ==== design/sticky_bank.sv ====
// Bank of sticky event flags with write-one clear
module sticky_bank #(parameter int unsigned W = 8)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clock_enable,
   sticky_if.bank   port
);

   logic [W-1:0] flags;
   logic [W-1:0] next_flags;

   // Set wins so an event in the clear cycle survives
   always_comb
   begin
      next_flags = (flags & ~port.clear) | port.event_set; // RQ13 RQ2
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         flags <= '0;
      else if (clock_enable)
         flags <= next_flags;
   end

   assign port.flags = flags; // RQ1

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_set_wins_clear: assert property ( // RQ13
      clock_enable && (port.event_set != '0) |=> ((flags & $past(port.event_set))
         == $past(port.event_set)))
      else $error("sticky event lost");

   a_clear_drops_bit: assert property ( // RQ2
      clock_enable && (port.clear != '0) && (port.event_set == '0)
         |=> ((flags & $past(port.clear)) == '0)
         && ((flags & ~$past(port.clear)) == ($past(flags) & ~$past(port.clear))))
      else $error("clear hit wrong bits");

   a_flags_hold: assert property ( // RQ1
      (!clock_enable || (port.clear == '0)) |=> ((flags & $past(flags)) == $past(flags)))
      else $error("sticky flag dropped without clear");

endmodule // sticky_bank

// ==== design/adc_link_ctrl_regs.sv ====
// Output and serial link control registers with sample output stage
module adc_link_ctrl_regs
   import adc_link_ctrl_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                reset_n,
   input  wire logic                clock_enable,
   input  wire logic                reg_write,
   input  wire logic                reg_read,
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [7:0]          reg_wdata,
   output logic      [7:0]          reg_rdata,
   output logic                     reg_rvalid,
   input  wire logic [NUM_CONV-1:0] overrange_event,
   input  wire logic                pll_lock_pin,
   input  wire logic                standby,
   input  wire logic [SAMPLE_W-1:0] sample_a_in,
   input  wire logic [SAMPLE_W-1:0] sample_b_in,
   input  wire logic [4:0]          cfg_lane_count,
   input  wire logic [7:0]          cfg_converter_count,
   input  wire logic [7:0]          cfg_octets_per_frame,
   output logic      [SAMPLE_W-1:0] sample_a_out,
   output logic      [SAMPLE_W-1:0] sample_b_out,
   output logic                     cgs_force,
   output logic                     link_powerdown,
   output logic      [3:0]          lane_rate_select,
   output logic                     quad_rate_preset_mode,
   output logic      [4:0]          lane_count,
   output logic      [7:0]          converter_count,
   output logic      [7:0]          octets_per_frame
);

   function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] addr,
                                input logic [ADDR_W-1:0] ofs);
      hit = strobe && (addr == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Sticky flag banks
   sticky_if #(.W(NUM_CONV)) ovr_if ();
   sticky_if #(.W(1))        loss_if ();

   sticky_bank #(.W(NUM_CONV)) u_overrange
   (
      .clock        (clock),
      .reset_n      (reset_n),
      .clock_enable (clock_enable),
      .port         (ovr_if.bank)
   );

   sticky_bank #(.W(1)) u_loss_of_lock
   (
      .clock        (clock),
      .reset_n      (reset_n),
      .clock_enable (clock_enable),
      .port         (loss_if.bank)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   logic [7:0] overrange_clear;
   logic       channel_swap;
   logic [3:0] lane_rate;
   logic [7:0] quad_rate_cfg;
   logic [7:0] link_ctrl1;
   logic [7:0] next_overrange_clear;
   logic       next_channel_swap;
   logic [3:0] next_lane_rate;
   logic [7:0] next_quad_rate_cfg;
   logic [7:0] next_link_ctrl1;
   logic       wr_ctrl1;

   always_comb
   begin
      next_overrange_clear = overrange_clear;
      next_channel_swap    = channel_swap;
      next_lane_rate       = lane_rate;
      next_quad_rate_cfg   = quad_rate_cfg;
      next_link_ctrl1      = link_ctrl1;
      if (hit(reg_write, reg_addr, OFS_OVR_CLEAR))
         next_overrange_clear = reg_wdata; // RQ11
      if (hit(reg_write, reg_addr, OFS_CHANNEL_SEL))
         next_channel_swap = reg_wdata[SWAP_BIT]; // RQ3
      if (hit(reg_write, reg_addr, OFS_PLL_CONTROL))
         next_lane_rate = reg_wdata[LANE_RATE_LSB +: 4]; // RQ4
      if (hit(reg_write, reg_addr, OFS_QUAD_RATE))
         next_quad_rate_cfg = reg_wdata;
      if (wr_ctrl1)
         next_link_ctrl1 = reg_wdata; // RQ12
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         overrange_clear <= RST_OVR_CLEAR;
         channel_swap    <= RST_SWAP;
         lane_rate       <= RST_LANE_RATE;
         quad_rate_cfg   <= RST_QUAD_RATE;
         link_ctrl1      <= RST_LINK_CTRL1;
      end
      else if (clock_enable)
      begin
         overrange_clear <= next_overrange_clear;
         channel_swap    <= next_channel_swap;
         lane_rate       <= next_lane_rate;
         quad_rate_cfg   <= next_quad_rate_cfg;
         link_ctrl1      <= next_link_ctrl1;
      end
   end

   assign wr_ctrl1         = hit(reg_write, reg_addr, OFS_LINK_CTRL1);
   assign link_powerdown   = link_ctrl1[POWERDOWN_BIT]; // RQ12
   assign lane_rate_select = lane_rate; // RQ4

   // Clear acts on the write itself, stored value is only readback
   assign ovr_if.event_set = overrange_event; // RQ1
   assign ovr_if.clear     = hit(reg_write, reg_addr, OFS_OVR_CLEAR) ? reg_wdata : '0; // RQ2

   ////////////////////////////////////////////////////////////////////////////
   // Lock synchroniser and loss detection
   logic lock_meta;
   logic lock_sync;
   logic lock_prev;
   logic next_lock_meta;
   logic next_lock_sync;
   logic next_lock_prev;

   always_comb
   begin
      next_lock_meta = pll_lock_pin;
      next_lock_sync = lock_meta;
      next_lock_prev = lock_sync;
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lock_meta <= 1'h0;
         lock_sync <= 1'h0;
         lock_prev <= 1'h0;
      end
      else if (clock_enable)
      begin
         lock_meta <= next_lock_meta;
         lock_sync <= next_lock_sync;
         lock_prev <= next_lock_prev;
      end
   end

   // Only a falling lock counts, so power-up before first lock is not a loss
   assign loss_if.event_set = lock_prev && !lock_sync; // RQ5
   assign loss_if.clear     = wr_ctrl1 && reg_wdata[POWERDOWN_BIT]; // RQ6

   ////////////////////////////////////////////////////////////////////////////
   // Register read port
   logic [7:0] rd_mux;
   logic [7:0] next_rdata;
   logic       next_rvalid;

   always_comb
   begin
      rd_mux = 8'h00;
      unique case (reg_addr)
         OFS_OVR_CLEAR:   rd_mux = overrange_clear;
         OFS_OVR_STATUS:  rd_mux = ovr_if.flags; // RQ1
         OFS_CHANNEL_SEL: rd_mux = {7'h00, channel_swap};
         OFS_PLL_CONTROL: rd_mux = {lane_rate, 4'h0};
         OFS_PLL_STATUS:  rd_mux = {lock_sync, 3'h0, loss_if.flags[0], 3'h0}; // RQ5
         OFS_QUAD_RATE:   rd_mux = quad_rate_cfg;
         OFS_LINK_CTRL1:  rd_mux = link_ctrl1;
         default:         rd_mux = 8'h00;
      endcase
      next_rdata  = reg_read ? rd_mux : reg_rdata;
      next_rvalid = reg_read;
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'h0;
      end
      else if (clock_enable)
      begin
         reg_rdata  <= next_rdata;
         reg_rvalid <= next_rvalid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sample output stage and link format
   logic [SAMPLE_W-1:0] next_sample_a;
   logic [SAMPLE_W-1:0] next_sample_b;
   logic                next_cgs_force;
   logic                next_preset;
   logic [4:0]          next_lane_count;
   logic [7:0]          next_converter_count;
   logic [7:0]          next_octets;
   logic                standby_cgs;

   assign standby_cgs = link_ctrl1[STANDBY_BIT];

   always_comb
   begin
      next_sample_a  = channel_swap ? sample_b_in : sample_a_in; // RQ3
      next_sample_b  = channel_swap ? sample_a_in : sample_b_in; // RQ3
      next_cgs_force = standby && standby_cgs; // RQ10
      if (standby && !standby_cgs)
      begin
         next_sample_a = '0; // RQ9
         next_sample_b = '0; // RQ9
      end
      // Any value other than fe leaves the preset off
      next_preset          = (quad_rate_cfg == QUAD_RATE_ON); // RQ7
      next_lane_count      = next_preset ? PRESET_LANES  : cfg_lane_count; // RQ8
      next_converter_count = next_preset ? PRESET_CONV   : cfg_converter_count; // RQ8
      next_octets          = next_preset ? PRESET_OCTETS : cfg_octets_per_frame; // RQ8
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sample_a_out          <= '0;
         sample_b_out          <= '0;
         cgs_force             <= 1'h0;
         quad_rate_preset_mode <= 1'h0;
         lane_count            <= 5'h00;
         converter_count       <= 8'h00;
         octets_per_frame      <= 8'h00;
      end
      else if (clock_enable)
      begin
         sample_a_out          <= next_sample_a;
         sample_b_out          <= next_sample_b;
         cgs_force             <= next_cgs_force;
         quad_rate_preset_mode <= next_preset;
         lane_count            <= next_lane_count;
         converter_count       <= next_converter_count;
         octets_per_frame      <= next_octets;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence lock_drop;
      clock_enable && lock_prev && !lock_sync;
   endsequence

   sequence loss_clear_write;
      clock_enable && wr_ctrl1 && reg_wdata[POWERDOWN_BIT];
   endsequence

   a_loss_sets_sticky: assert property (lock_drop |=> loss_if.flags[0]) // RQ5
      else $error("loss of lock not recorded");

   a_loss_only_ctrl: assert property ( // RQ6
      clock_enable && loss_if.flags[0] && !(wr_ctrl1 && reg_wdata[POWERDOWN_BIT])
         |=> loss_if.flags[0])
      else $error("loss of lock cleared without control write");

   a_loss_clear_write: assert property ( // RQ6
      loss_clear_write ##0 !loss_if.event_set |=> !loss_if.flags[0])
      else $error("loss of lock not cleared by control write");

   a_swap_exchange: assert property ( // RQ3
      clock_enable && channel_swap && !standby
         |=> (sample_a_out == $past(sample_b_in)) && (sample_b_out == $past(sample_a_in)))
      else $error("channel swap not applied");

   a_standby_zero: assert property ( // RQ9
      clock_enable && standby && !standby_cgs
         |=> (sample_a_out == '0) && (sample_b_out == '0) && !cgs_force)
      else $error("standby samples not zero");

   a_standby_cgs: assert property ( // RQ10
      clock_enable && standby && standby_cgs |=> cgs_force)
      else $error("standby did not force code group sync");

   a_preset_format: assert property ( // RQ7
      clock_enable && quad_rate_cfg == QUAD_RATE_ON
         |=> quad_rate_preset_mode && lane_count == PRESET_LANES
         && converter_count == PRESET_CONV && octets_per_frame == PRESET_OCTETS)
      else $error("quad rate preset format wrong");

   a_preset_off: assert property ( // RQ8
      clock_enable && quad_rate_cfg == QUAD_RATE_OFF
         |=> !quad_rate_preset_mode && lane_count == $past(cfg_lane_count)
         && octets_per_frame == $past(cfg_octets_per_frame))
      else $error("separate link settings not used");

   a_status_readback: assert property ( // RQ1
      clock_enable && reg_read && reg_addr == OFS_OVR_STATUS
         |=> reg_rvalid && reg_rdata == $past(ovr_if.flags))
      else $error("overrange status readback wrong");

   a_powerdown_write: assert property ( // RQ12
      clock_enable && wr_ctrl1 |=> link_powerdown == $past(reg_wdata[POWERDOWN_BIT]))
      else $error("link power down not following write");

endmodule // adc_link_ctrl_regs

// ==== bench/adc_link_ctrl_regs_tb.sv ====
// Self-checking bench for the converter output and serial link control registers
module adc_link_ctrl_regs_tb
   import adc_link_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic                clock                = 1'b0;
   logic                reset_n              = 1'b0;
   logic                clock_enable         = 1'b1;
   logic                reg_write            = 1'b0;
   logic                reg_read             = 1'b0;
   logic [ADDR_W-1:0]   reg_addr             = '0;
   logic [7:0]          reg_wdata            = 8'h00;
   logic [7:0]          reg_rdata;
   logic                reg_rvalid;
   logic [NUM_CONV-1:0] overrange_event      = '0;
   logic                pll_lock_pin         = 1'b0;
   logic                standby              = 1'b0;
   logic [SAMPLE_W-1:0] sample_a_in          = '0;
   logic [SAMPLE_W-1:0] sample_b_in          = '0;
   logic [4:0]          cfg_lane_count       = 5'h04;
   logic [7:0]          cfg_converter_count  = 8'h01;
   logic [7:0]          cfg_octets_per_frame = 8'h01;
   logic [SAMPLE_W-1:0] sample_a_out;
   logic [SAMPLE_W-1:0] sample_b_out;
   logic                cgs_force;
   logic                link_powerdown;
   logic [3:0]          lane_rate_select;
   logic                quad_rate_preset_mode;
   logic [4:0]          lane_count;
   logic [7:0]          converter_count;
   logic [7:0]          octets_per_frame;
   logic [7:0]          exp_q[$];
   int                  err_total            = 0;
   int                  samples_checked      = 0;

   ////////////////////////////////////////////////////////////////////////////
   always #2 clock = ~clock;

   adc_link_ctrl_regs adc_link_ctrl_regs_i
   (
      .clock                (clock),
      .reset_n              (reset_n),
      .clock_enable         (clock_enable),
      .reg_write            (reg_write),
      .reg_read             (reg_read),
      .reg_addr             (reg_addr),
      .reg_wdata            (reg_wdata),
      .reg_rdata            (reg_rdata),
      .reg_rvalid           (reg_rvalid),
      .overrange_event      (overrange_event),
      .pll_lock_pin         (pll_lock_pin),
      .standby              (standby),
      .sample_a_in          (sample_a_in),
      .sample_b_in          (sample_b_in),
      .cfg_lane_count       (cfg_lane_count),
      .cfg_converter_count  (cfg_converter_count),
      .cfg_octets_per_frame (cfg_octets_per_frame),
      .sample_a_out         (sample_a_out),
      .sample_b_out         (sample_b_out),
      .cgs_force            (cgs_force),
      .link_powerdown       (link_powerdown),
      .lane_rate_select     (lane_rate_select),
      .quad_rate_preset_mode(quad_rate_preset_mode),
      .lane_count           (lane_count),
      .converter_count      (converter_count),
      .octets_per_frame     (octets_per_frame)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic check_port(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_rd(input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR reg_rdata expected %h seen %h", exp, got);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Called at a falling edge; a spare cycle keeps strobes from toggling twice at once
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [7:0] ev = 8'h00);
      reg_write = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      overrange_event = ev;
      @(negedge clock);
      reg_write = 1'b0;
      overrange_event = 8'h00;
      @(negedge clock);
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      reg_read = 1'b1;
      reg_addr = a;
      exp_q.push_back(exp);
      @(negedge clock);
      reg_read = 1'b0;
      @(negedge clock);
   endtask

   task automatic samp(input logic sw, input logic zero, input logic cgs);
      logic [15:0] a;
      logic [15:0] b;
      a = 16'($urandom);
      b = 16'($urandom);
      sample_a_in = a;
      sample_b_in = b;
      @(negedge clock);
      check_port("sample_a_out", zero ? 16'h0000 : (sw ? b : a), sample_a_out);
      check_port("sample_b_out", zero ? 16'h0000 : (sw ? a : b), sample_b_out);
      check_port("cgs_force", 16'(cgs), 16'(cgs_force));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Read data monitor; an answer with nothing pending is itself a fault
   always @(negedge clock)
   begin
      if (reg_rvalid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check_rd(8'h00, 8'hxx);
         else
            check_rd(exp_q.pop_front(), reg_rdata);
      end
   end

   initial
   begin
      repeat (5000) @(posedge clock);
      err_total++;
      $display("ERROR watchdog expected finish seen hang");
      final_report();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      int unsigned seed_init;
      logic [7:0]  r;
      logic [11:0] addrs[8];
      logic [7:0]  rstv[8];
      logic [3:0]  codes[4];
      addrs = '{12'h562, 12'h563, 12'h564, 12'h56e, 12'h56f, 12'h570, 12'h571, 12'h600};
      rstv = '{8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'hff, 8'h14, 8'h00};
      codes = '{RATE_6G75_13G5, RATE_3G375_6G75, RATE_13G5_16G, RATE_1G69_3G375};
      seed_init = $urandom(32'he078544f);
      cfg_lane_count = 5'($urandom);
      cfg_converter_count = 8'($urandom);
      cfg_octets_per_frame = 8'($urandom);
      repeat (6) @(negedge clock);
      reset_n = 1'b1;
      @(negedge clock);
      check_port("lane_rate_select", 16'h0003, 16'(lane_rate_select));
      check_port("preset_mode", 16'h0000, 16'(quad_rate_preset_mode));
      check_port("lane_count", 16'(cfg_lane_count), 16'(lane_count));
      for (int i = 0; i < 8; i++)
         rd(addrs[i], rstv[i]);
      for (int i = 0; i < 4; i++)
      begin
         wr(OFS_PLL_CONTROL, {codes[i], 4'hf});
         check_port("lane_rate_select", 16'(codes[i]), 16'(lane_rate_select));
         rd(OFS_PLL_CONTROL, {codes[i], 4'h0});
      end
      // Channel swap, and a write that must be ignored while frozen
      samp(1'b0, 1'b0, 1'b0);
      wr(OFS_CHANNEL_SEL, 8'hff);
      rd(OFS_CHANNEL_SEL, 8'h01);
      samp(1'b1, 1'b0, 1'b0);
      clock_enable = 1'b0;
      wr(OFS_CHANNEL_SEL, 8'h00);
      clock_enable = 1'b1;
      rd(OFS_CHANNEL_SEL, 8'h01);
      // Overrange sticky flags, carried in on an unmapped write
      r = 8'($urandom) | 8'h01;
      wr(12'h600, 8'h00, r);
      rd(OFS_OVR_STATUS, r);
      wr(OFS_OVR_STATUS, 8'h00);
      rd(OFS_OVR_STATUS, r);
      wr(OFS_OVR_CLEAR, 8'hff);
      rd(OFS_OVR_STATUS, 8'h00);
      rd(OFS_OVR_CLEAR, 8'hff);
      wr(12'h600, 8'h00, 8'h05);
      wr(OFS_OVR_CLEAR, 8'h04);
      rd(OFS_OVR_STATUS, 8'h01);
      wr(OFS_OVR_CLEAR, 8'h04, 8'h04);
      rd(OFS_OVR_STATUS, 8'h05);
      wr(OFS_OVR_CLEAR, 8'hff);
      rd(OFS_OVR_STATUS, 8'h00);
      // Loss of lock is cleared only by link control bit 0
      pll_lock_pin = 1'b1;
      repeat (6) @(negedge clock);
      rd(OFS_PLL_STATUS, 8'h80);
      pll_lock_pin = 1'b0;
      repeat (6) @(negedge clock);
      rd(OFS_PLL_STATUS, 8'h08);
      wr(OFS_LINK_CTRL1, 8'h14);
      rd(OFS_PLL_STATUS, 8'h08);
      wr(OFS_LINK_CTRL1, 8'h15);
      check_port("link_powerdown", 16'h0001, 16'(link_powerdown));
      rd(OFS_PLL_STATUS, 8'h00);
      wr(OFS_LINK_CTRL1, 8'h14);
      check_port("link_powerdown", 16'h0000, 16'(link_powerdown));
      // Quad rate preset and back to the separate settings
      wr(OFS_QUAD_RATE, QUAD_RATE_ON);
      @(negedge clock);
      check_port("preset_mode", 16'h0001, 16'(quad_rate_preset_mode));
      check_port("lane_count", 16'h0008, 16'(lane_count));
      check_port("converter_count", 16'h0002, 16'(converter_count));
      check_port("octets_per_frame", 16'h0002, 16'(octets_per_frame));
      rd(OFS_QUAD_RATE, 8'hfe);
      wr(OFS_QUAD_RATE, QUAD_RATE_OFF);
      @(negedge clock);
      check_port("preset_mode", 16'h0000, 16'(quad_rate_preset_mode));
      check_port("lane_count", 16'(cfg_lane_count), 16'(lane_count));
      check_port("converter_count", 16'(cfg_converter_count), 16'(converter_count));
      check_port("octets_per_frame", 16'(cfg_octets_per_frame), 16'(octets_per_frame));
      // Standby in both selections, swap still on
      standby = 1'b1;
      samp(1'b1, 1'b1, 1'b0);
      wr(OFS_LINK_CTRL1, 8'h94);
      rd(OFS_LINK_CTRL1, 8'h94);
      samp(1'b1, 1'b0, 1'b1);
      standby = 1'b0;
      samp(1'b1, 1'b0, 1'b0);
      repeat (4) @(negedge clock);
      check_port("pending_reads", 16'h0000, 16'(exp_q.size()));
      final_report();
   end

endmodule // adc_link_ctrl_regs_tb
